//--- core/ubpc_pkg.sv
/*
  Constants for the UART bridge pin-control block: field positions of the
  modem status, enhanced features and interrupt enable images, and the
  settle width of the pin synchronisers.
  Assumes a single 100 MHz clock domain.
*/
package ubpc_pkg;
  localparam int UBPC_CHANS = 2;
  localparam int UBPC_SYNC_STAGES = 3;
  // Modem status bit that shows clear-to-send
  localparam int UBPC_MSR_CTS_BIT = 4;
  // Enhanced features bit that enables automatic clear-to-send
  localparam int UBPC_EFR_AUTO_CTS_BIT = 7;
  // Interrupt enable / cause bit positions
  localparam int UBPC_IRQ_RX_DATA = 0;
  localparam int UBPC_IRQ_TX_SPACE = 1;
  localparam int UBPC_IRQ_RX_ERR = 2;
  localparam int UBPC_IRQ_MODEM = 3;
  localparam int UBPC_IRQ_PIN_CHG = 4;
  localparam int UBPC_IRQ_W = 5;
  localparam logic [7:0] UBPC_REG_RESET = 8'h00;
  // Base address bit 6..2 of the slave address; bits 1:0 come from pins
  localparam logic [6:0] UBPC_I2C_BASE_ADDR = 7'h48;
  typedef enum logic {UBPC_MODE_SPI, UBPC_MODE_I2C} ubpc_mode_t;
endpackage

//--- core/ubpc_sync.sv
/*
  Three-flop pin synchroniser with agreement filter.
  Assumes the input is asynchronous to clk_i; the output changes only
  when the second and third stages agree.
*/
`timescale 1ns/10ps
module ubpc_sync
  import ubpc_pkg::*;
#(
  parameter logic RESET_VAL = 1'b1
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic async_i,
  output logic level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } ubpc_sync_st_t;
  ubpc_sync_st_t st_q;
  ubpc_sync_st_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.s1 = async_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    if (st_q.s2 == st_q.s3)
    begin
      st_d.lvl = st_q.s3;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q <= {4{RESET_VAL}};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level_o = st_q.lvl;
endmodule

//--- core/ubpc_top.sv
/*
  Pin-level control of a dual-channel UART bridge: host interface select,
  shared chip-select / address pin, clear-to-send status and gating, and
  the open-drain interrupt output.
  Assumes the UART datapath supplies per-channel event pulses and the
  register file supplies the enable and feature bytes.

  Host interface select:
    The bus-select pin is filtered like any other pin and its settled
    level picks I2C (high) or SPI (low). Both mode outputs come from one
    register, so exactly one of them is high at any time.

  Shared select / address pin:
    In SPI mode the filtered pin is the active-low chip select and the
    select output follows it combinationally from the filter registers.
    In I2C mode the filtered pin and the second address pin form the low
    two bits of the slave address. The address register freezes while the
    filtered bus-select level is low, at the same clock edge as the mode register.

  Clear-to-send:
    Each channel's pin is filtered, shown inverted in the status image
    and compared with its previous filtered level to give a one-cycle
    change pulse. Transmit is permitted unless automatic flow control is
    on and the remote end is not ready.

  Interrupt:
    Enabled causes latch into a pending word per channel; a clear pulse
    empties the word, but a cause arriving in the same cycle still
    latches. The pin itself is open-drain: the data level is always low
    and the output enable follows the OR of the pending words one cycle late.

  Reset leaves the filters at the inactive pin levels, so the real pin
  levels appear a few cycles after reset is released.
*/
// Behaviour
// - Bus-select high gives I2C slave mode, low gives SPI slave mode.
// - In SPI mode the shared pin is the active-low, filtered chip select.
// - In I2C mode shared pin plus address bit 1 set slave address.
// - Low clear-to-send means the remote end accepts transmit data.
// - Clear-to-send state appears in modem status bit 4 per channel.
// - Clear-to-send gates transmit only with auto flow control bit 7 set.
// - Interrupt is open-drain, active low, only for enabled sources.
// - Causes: pin change, receive error, data, transmit space, modem change.
`timescale 1ns/10ps
module ubpc_top
  import ubpc_pkg::*;
#(
  parameter int CHANS = UBPC_CHANS
)
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic bus_select_i,
  input wire logic chip_select_or_addr_bit0_i,
  input wire logic address_select_bit1_i,
  input wire logic clear_to_send_chan_a_n_i,
  input wire logic clear_to_send_chan_b_n_i,
  input wire logic [7:0] enhanced_features_reg_a_i,
  input wire logic [7:0] enhanced_features_reg_b_i,
  input wire logic [7:0] interrupt_enable_reg_a_i,
  input wire logic [7:0] interrupt_enable_reg_b_i,
  input wire logic [CHANS-1:0] pin_change_i,
  input wire logic [CHANS-1:0] rx_error_i,
  input wire logic [CHANS-1:0] rx_data_avail_i,
  input wire logic [CHANS-1:0] tx_space_avail_i,
  input wire logic [CHANS-1:0] cause_clear_i,
  output logic i2c_mode_o,
  output logic spi_mode_o,
  output logic spi_select_o,
  output logic [6:0] i2c_slave_addr_o,
  output logic [7:0] modem_status_reg_a_o,
  output logic [7:0] modem_status_reg_b_o,
  output logic [CHANS-1:0] tx_allowed_o,
  output logic irq_n_o,
  output logic irq_n_oe_o
);
  typedef struct packed {
    logic mode;
    logic [6:0] addr;
    logic [CHANS-1:0] cts_prev;
    logic [CHANS-1:0] delta_cts;
    logic [CHANS-1:0][UBPC_IRQ_W-1:0] pend;
    logic [CHANS-1:0] tx_ok;
    logic irq;
  } ubpc_st_t;
  ubpc_st_t st_q;
  ubpc_st_t st_d;

  logic sel_s;
  logic a0_s;
  logic a1_s;
  logic [CHANS-1:0] cts_n_raw;
  logic [CHANS-1:0] cts_n_s;
  logic [CHANS-1:0][7:0] enhanced_features_reg;
  logic [CHANS-1:0][7:0] interrupt_enable_reg;
  logic [CHANS-1:0][UBPC_IRQ_W-1:0] ev;
  logic [CHANS-1:0][7:0] modem_status_reg;

  assign cts_n_raw = {clear_to_send_chan_b_n_i, clear_to_send_chan_a_n_i};
  assign enhanced_features_reg = {enhanced_features_reg_b_i, enhanced_features_reg_a_i};
  assign interrupt_enable_reg = {interrupt_enable_reg_b_i, interrupt_enable_reg_a_i};

  ubpc_sync #(.RESET_VAL(1'b1)) u_sync_sel
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(bus_select_i),
    .level_o(sel_s)
  );
  // Schmitt-style filtering of the shared select pin
  ubpc_sync #(.RESET_VAL(1'b1)) u_sync_a0
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(chip_select_or_addr_bit0_i),
    .level_o(a0_s)
  );
  ubpc_sync #(.RESET_VAL(1'b1)) u_sync_a1
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .async_i(address_select_bit1_i),
    .level_o(a1_s)
  );

  genvar g;
  generate
    for (g = 0; g < CHANS; g++)
    begin : g_cts
      ubpc_sync #(.RESET_VAL(1'b1)) u_sync_cts
      (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .async_i(cts_n_raw[g]),
        .level_o(cts_n_s[g])
      );
      always_comb
      begin
        ev[g] = '0;
        ev[g][UBPC_IRQ_RX_DATA] = rx_data_avail_i[g];
        ev[g][UBPC_IRQ_TX_SPACE] = tx_space_avail_i[g];
        ev[g][UBPC_IRQ_RX_ERR] = rx_error_i[g];
        ev[g][UBPC_IRQ_MODEM] = st_q.delta_cts[g];
        ev[g][UBPC_IRQ_PIN_CHG] = pin_change_i[g];
      end

      always_comb
      begin
        modem_status_reg[g] = UBPC_REG_RESET;
        // Level bit reads high while the remote end is ready
        modem_status_reg[g][UBPC_MSR_CTS_BIT] = !cts_n_s[g];
        // Change bit pulses for one cycle after a level change
        modem_status_reg[g][0] = st_q.delta_cts[g];
      end
    end
  endgenerate

  always_comb
  begin
    st_d = st_q;
    st_d.mode = sel_s;
    if (sel_s)
    begin
      st_d.addr = {UBPC_I2C_BASE_ADDR[6:2], a1_s, a0_s};
    end
    st_d.cts_prev = cts_n_s;
    st_d.irq = 1'b0;
    for (int c = 0; c < CHANS; c++)
    begin
      st_d.delta_cts[c] = cts_n_s[c] ^ st_q.cts_prev[c];
      // High clear-to-send holds data back only under auto flow control
      st_d.tx_ok[c] = !enhanced_features_reg[c][UBPC_EFR_AUTO_CTS_BIT] || !cts_n_s[c];
      if (cause_clear_i[c])
      begin
        st_d.pend[c] = '0;
      end
      // Set wins over clear; only enabled causes latch
      st_d.pend[c] = st_d.pend[c] | (ev[c] & interrupt_enable_reg[c][UBPC_IRQ_W-1:0]);
      st_d.irq = st_d.irq | (|st_q.pend[c]);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_q <= '0;
      st_q.mode <= 1'b1;
      st_q.addr <= UBPC_I2C_BASE_ADDR;
      st_q.cts_prev <= '1;
      st_q.tx_ok <= '1;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign i2c_mode_o = (st_q.mode == UBPC_MODE_I2C);
  assign spi_mode_o = (st_q.mode == UBPC_MODE_SPI);
  assign spi_select_o = spi_mode_o && !a0_s;
  assign i2c_slave_addr_o = st_q.addr;
  assign modem_status_reg_a_o = modem_status_reg[0];
  assign modem_status_reg_b_o = modem_status_reg[1];
  assign tx_allowed_o = st_q.tx_ok;
  assign irq_n_o = 1'b0;
  assign irq_n_oe_o = st_q.irq;
endmodule

//--- verif/ubpc_modem.sv
/* Remote modem: drives clear-to-send on its own clock.
   The bench says per channel whether it is ready. */
`timescale 1ns/10ps
module ubpc_modem
(
  input logic [1:0] ready_i,
  output logic [1:0] cts_n_o
);
  logic lclk = 1'b0;
  initial cts_n_o = 2'h3;
  always #62.5 lclk = ~lclk;
  always @(posedge lclk) cts_n_o <= ~ready_i;
endmodule

//--- verif/ubpc_top_asserts.sv
/* Checker on ubpc_top ports.
   Bound below; one clock domain. */
`timescale 1ns/10ps
module ubpc_top_asserts
  import ubpc_pkg::*;
#(
  parameter int CHANS = UBPC_CHANS
)
(
  input logic clk_i,
  input logic resetn_i,
  input logic bus_select_i,
  input logic chip_select_or_addr_bit0_i,
  input logic clear_to_send_chan_a_n_i,
  input logic [7:0] interrupt_enable_reg_a_i,
  input logic [CHANS-1:0] rx_data_avail_i,
  input logic [CHANS-1:0] cause_clear_i,
  input logic i2c_mode_o,
  input logic spi_mode_o,
  input logic spi_select_o,
  input logic [7:0] modem_status_reg_a_o,
  input logic irq_n_o,
  input logic irq_n_oe_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  mode_a:
    assert property (($stable(bus_select_i) && resetn_i)[*8] |->
      i2c_mode_o == bus_select_i) else $error("mode");
  one_mode_a:
    assert property (i2c_mode_o != spi_mode_o) else $error("modes");
  cs_on_a:
    assert property ((resetn_i && !bus_select_i &&
      !chip_select_or_addr_bit0_i)[*8]
      |-> spi_select_o) else $error("select");
  cs_low_a:
    assert property ($rose(spi_select_o) |->
      !$past(chip_select_or_addr_bit0_i, 3) ||
      !$past(chip_select_or_addr_bit0_i, 4)) else $error("select early");
  cts_bit_a:
    assert property (($stable(clear_to_send_chan_a_n_i) && resetn_i)[*8] |->
      modem_status_reg_a_o[4] != clear_to_send_chan_a_n_i) else $error("cts");
  irq_pin_a:
    assert property (!irq_n_o) else $error("irq level");
  irq_set_a:
    assert property (rx_data_avail_i[0] && interrupt_enable_reg_a_i[0]
      |-> ##2 irq_n_oe_o) else $error("irq late");
  irq_free_a:
    assert property ($fell(irq_n_oe_o) |-> $past(|cause_clear_i, 2))
      else $error("irq early");
endmodule

bind ubpc_top ubpc_top_asserts #(.CHANS(CHANS)) chk (.*);

//--- verif/ubpc_top_tb_top.sv
/* Bench for ubpc_top against an in-bench model.
   Assumes the bound checker and the modem model. */
`timescale 1ns/10ps
module ubpc_top_tb_top;
  import ubpc_pkg::*;
  logic clk_i = 0, resetn_i = 0, bus_select_i = 0;
  logic chip_select_or_addr_bit0_i = 1, address_select_bit1_i = 0;
  logic clear_to_send_chan_a_n_i, clear_to_send_chan_b_n_i;
  logic [7:0] enhanced_features_reg_a_i = 0, enhanced_features_reg_b_i = 0;
  logic [7:0] interrupt_enable_reg_a_i = 0, interrupt_enable_reg_b_i = 0;
  logic [1:0] pin_change_i = 0, rx_error_i = 0, rx_data_avail_i = 0, rdy = 0;
  logic [1:0] tx_space_avail_i = 0, cause_clear_i = 0, tx_allowed_o;
  logic i2c_mode_o, spi_mode_o, spi_select_o, irq_n_o, irq_n_oe_o;
  logic [6:0] i2c_slave_addr_o, ea = {UBPC_I2C_BASE_ADDR[6:2], 2'b11};
  logic [7:0] modem_status_reg_a_o, modem_status_reg_b_o;
  integer seed = 55, bad_count = 0, checks = 0, ev;
  always #5 clk_i = ~clk_i;
  ubpc_top dut (.*);
  ubpc_modem remote (.ready_i(rdy),
    .cts_n_o({clear_to_send_chan_b_n_i, clear_to_send_chan_a_n_i}));
  task cmp(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %0t %h %h", $time, g, e);
    end
  endtask
  task end_sim;
    if (bad_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task step(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  initial
  begin
    step(6);
    resetn_i = 1;
    repeat (40)
    begin
      ev = $random(seed);
      {bus_select_i, chip_select_or_addr_bit0_i} = ev[1:0];
      address_select_bit1_i = ev[2];
      rdy = ev[4:3];
      {enhanced_features_reg_a_i, enhanced_features_reg_b_i} = ev[23:8];
      step(40);
      if (bus_select_i)
        ea = {ea[6:2], address_select_bit1_i, chip_select_or_addr_bit0_i};
      cmp(i2c_mode_o, bus_select_i);
      cmp(spi_mode_o, !bus_select_i);
      cmp(spi_select_o, !bus_select_i && !chip_select_or_addr_bit0_i);
      cmp(i2c_slave_addr_o, ea);
      cmp({modem_status_reg_b_o[4], modem_status_reg_a_o[4]}, rdy);
      cmp(tx_allowed_o, 2'(rdy | ~{ev[15], ev[23]}));
      ev = $random(seed);
      {interrupt_enable_reg_a_i, interrupt_enable_reg_b_i} = ev[15:0];
      {pin_change_i, rx_error_i, rx_data_avail_i, tx_space_avail_i} = ev[23:16];
      step(1);
      {pin_change_i, rx_error_i, rx_data_avail_i, tx_space_avail_i} = '0;
      step(2);
      cmp(irq_n_oe_o, |(ev[12:8] & {ev[22], 1'b0, ev[20], ev[16], ev[18]})
        | |(ev[4:0] & {ev[23], 1'b0, ev[21], ev[17], ev[19]}));
      cause_clear_i = 2'h3;
      step(1);
      cause_clear_i = 2'h0;
      step(3);
      cmp(irq_n_oe_o, 8'h00);
      {interrupt_enable_reg_a_i, interrupt_enable_reg_b_i} = 16'h0000;
    end
    end_sim;
  end
endmodule
